/* logic/watchdog_ctrl_pkg.sv */
// Register map, field layout, key values and state encoding of the watchdog control logic
package watchdog_ctrl_pkg;

  // APB geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // Register byte offsets
  localparam logic [7:0]  WDC_OFS       = 8'h00;
  localparam logic [7:0]  TGC_OFS       = 8'h04;
  localparam logic [7:0]  IST_OFS       = 8'h08;
  localparam logic [7:0]  ICL_OFS       = 8'h0C;
  localparam logic [7:0]  IEN_OFS       = 8'h10;

  // Watchdog control fields
  localparam int          KEY_HI        = 31;
  localparam int          KEY_LO        = 16;
  localparam int          FLAG_BIT      = 15;
  localparam int          EN_BIT        = 14;
  localparam int          RSV_HI        = 13;
  localparam int          RSV_LO        = 12;

  // Global timer control fields
  localparam int          MODE_HI       = 3;
  localparam int          MODE_LO       = 2;
  localparam int          UHR_BIT       = 1;
  localparam int          LHR_BIT       = 0;

  // Service keys and watchdog mode code
  localparam logic [15:0] KEY_FIRST     = 16'hA5C6;
  localparam logic [15:0] KEY_SECOND    = 16'hDA7E;
  localparam logic [1:0]  MODE_WATCHDOG = 2'h2;

  // Reset values
  localparam logic [15:0] KEY_RST       = 16'h0000;
  localparam logic [1:0]  RSV_RST       = 2'h0;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam logic [1:0]  HALF_RST      = 2'h0;

  // Interrupt status layout
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_TIMEOUT   = 0;
  localparam int          IRQ_SERVICE   = 1;
  localparam int          IRQ_BADKEY    = 2;
  localparam logic [2:0]  IRQ_RST       = 3'h0;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_ENABLED = 2'b01,
    ST_ACTIVE  = 2'b11
  } wd_state_e;

endpackage

/* logic/watchdog_control_service_logic.sv */
// What this block does
// - Key field sits in control bits 31..16, readable and writable.
// - Only key A5C6h then next key write DA7Eh services the watchdog.
// - In regular timer modes key writes never service the timer.
// - Time-out sets the flag at bit 15; zero means no time-out.
// - Flag clears when the watchdog gets enabled and on reset.
// - Writing one to the flag position clears the flag.
// - Bit 14 is the watchdog enable; one enables, zero disables until the watchdog is active, after which writes to it are ignored.
// - Watchdog behaviour applies only with timer mode select equal 2h.
// - In active state, half-timer reset control changes have no effect.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module watchdog_control_service_logic
  import watchdog_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer core
  input  wire logic              wdt_expire,
  output logic                   wdt_service,
  output logic                   wdt_armed,
  output logic                   wdt_active,
  output logic      [1:0]        timer_mode,
  output logic                   lower_half_run,
  output logic                   upper_half_run,
  // Interrupt
  output logic                   irq
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  wd_state_e         state_r;
  wd_state_e         state_nxt;
  logic [15:0]       key_r;
  logic              flag_r;
  logic              en_r;
  logic [1:0]        rsv_r;
  logic [1:0]        mode_r;
  logic              lower_ctrl_r;
  logic              upper_ctrl_r;
  logic              lower_run_r;
  logic              upper_run_r;
  logic              key_half_r;
  logic              service_r;
  logic [IRQ_W-1:0]  ist_r;
  logic [IRQ_W-1:0]  ien_r;
  logic [IRQ_W-1:0]  ev;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] rd_mux;
  logic              pslverr_r;
  logic              setup_ph;
  logic              access_ph;
  logic              wr_en;
  logic              mapped;
  logic              wr_wdc;
  logic              wr_tgc;
  logic              wr_icl;
  logic              wr_ien;
  logic              wd_mode;
  logic              key_open;
  logic [15:0]       key_in;
  logic              key_first;
  logic              key_done;
  logic              key_broken;
  logic              flag_set;
  logic              flag_clr;

  // Bus phases and decode
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en     = access_ph && pwrite;
  assign mapped    = hit(paddr, WDC_OFS) || hit(paddr, TGC_OFS) || hit(paddr, IST_OFS) ||
                     hit(paddr, ICL_OFS) || hit(paddr, IEN_OFS);
  assign wr_wdc    = wr_en && hit(paddr, WDC_OFS);
  assign wr_tgc    = wr_en && hit(paddr, TGC_OFS);
  assign wr_icl    = wr_en && hit(paddr, ICL_OFS);
  assign wr_ien    = wr_en && hit(paddr, IEN_OFS);

  // Key sequence decode, open only in watchdog mode with the enable set
  assign wd_mode    = (mode_r == MODE_WATCHDOG);
  assign key_in     = pwdata[KEY_HI:KEY_LO];
  assign key_open   = wd_mode && (en_r || pwdata[EN_BIT]);
  assign key_first  = wr_wdc && key_open && (key_in == KEY_FIRST);
  assign key_done   = wr_wdc && key_open && key_half_r && (key_in == KEY_SECOND);
  assign key_broken = wr_wdc && key_open && key_half_r && !key_done && !key_first;

  // Flag causes
  assign flag_set = wdt_expire && (state_r == ST_ACTIVE);
  assign flag_clr = wr_wdc && (pwdata[FLAG_BIT] || (pwdata[EN_BIT] && !en_r));

  // Key field storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_r <= KEY_RST;
      rsv_r <= RSV_RST;
    end else if (wr_wdc) begin
      key_r <= key_in;
      rsv_r <= pwdata[RSV_HI:RSV_LO];
    end
  end

  // First half of the key sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_half_r <= 1'b0;
    end else if (!wd_mode) begin
      key_half_r <= 1'b0;
    end else if (wr_wdc) begin
      key_half_r <= key_first;
    end
  end

  // Service pulse to the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service_r <= 1'b0;
    end else begin
      service_r <= key_done;
    end
  end

  // Enable bit; activation forces it on so an active watchdog never reads disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
    end else if (key_done) begin
      en_r <= 1'b1;
    end else if (wr_wdc && state_r != ST_ACTIVE) begin
      en_r <= pwdata[EN_BIT];
    end
  end

  // Time-out flag, a new time-out wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // Watchdog state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (key_done) begin
          state_nxt = ST_ACTIVE;
        end else if (en_r && wd_mode) begin
          state_nxt = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (key_done) begin
          state_nxt = ST_ACTIVE;
        end else if (!en_r || !wd_mode) begin
          state_nxt = ST_OFF;
        end
      end
      ST_ACTIVE: begin
        state_nxt = ST_ACTIVE;
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Global timer control; mode is frozen while active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r       <= MODE_RST;
      lower_ctrl_r <= HALF_RST[0];
      upper_ctrl_r <= HALF_RST[1];
    end else if (wr_tgc) begin
      if (state_r != ST_ACTIVE) begin
        mode_r <= pwdata[MODE_HI:MODE_LO];
      end
      lower_ctrl_r <= pwdata[LHR_BIT];
      upper_ctrl_r <= pwdata[UHR_BIT];
    end
  end

  // Half-timer run controls stop following software once active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_run_r <= HALF_RST[0];
      upper_run_r <= HALF_RST[1];
    end else if (state_r != ST_ACTIVE) begin
      lower_run_r <= lower_ctrl_r;
      upper_run_r <= upper_ctrl_r;
    end
  end

  // Interrupt status, enable and clear
  assign ev[IRQ_TIMEOUT] = flag_set;
  assign ev[IRQ_SERVICE] = key_done;
  assign ev[IRQ_BADKEY]  = key_broken;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= IRQ_RST;
    end else if (wr_icl) begin
      ist_r <= (ist_r & ~pwdata[IRQ_W-1:0]) | ev;
    end else begin
      ist_r <= ist_r | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= IRQ_RST;
    end else if (wr_ien) begin
      ien_r <= pwdata[IRQ_W-1:0];
    end
  end

  // Read data, captured in the setup phase
  always_comb begin
    rd_mux = '0;
    if (hit(paddr, WDC_OFS)) begin
      rd_mux[KEY_HI:KEY_LO] = key_r;
      rd_mux[FLAG_BIT]      = flag_r;
      rd_mux[EN_BIT]        = en_r;
      rd_mux[RSV_HI:RSV_LO] = rsv_r;
    end else if (hit(paddr, TGC_OFS)) begin
      rd_mux[MODE_HI:MODE_LO] = mode_r;
      rd_mux[UHR_BIT]         = upper_ctrl_r;
      rd_mux[LHR_BIT]         = lower_ctrl_r;
    end else if (hit(paddr, IST_OFS)) begin
      rd_mux[IRQ_W-1:0] = ist_r;
    end else if (hit(paddr, IEN_OFS)) begin
      rd_mux[IRQ_W-1:0] = ien_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? '0 : rd_mux;
      pslverr_r <= !mapped;
    end else if (!psel) begin
      pslverr_r <= 1'b0;
    end
  end

  assign prdata         = prdata_r;
  assign pslverr        = pslverr_r;
  assign pready         = 1'b1;
  assign wdt_service    = service_r;
  assign wdt_armed      = (state_r == ST_ENABLED);
  assign wdt_active     = (state_r == ST_ACTIVE);
  assign timer_mode     = mode_r;
  assign lower_half_run = lower_run_r;
  assign upper_half_run = upper_run_r;
  assign irq            = |(ist_r & ien_r);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_key_store:
    assert property (wr_wdc |=> key_r == $past(pwdata[KEY_HI:KEY_LO]))
    else $error("key field did not take written value");

  a_key_service:
    assert property (key_done |=> wdt_service && wdt_active)
    else $error("valid key sequence did not service");

  a_service_single:
    assert property (wdt_service |=> !wdt_service)
    else $error("service pulse longer than one cycle");

  a_no_stray_service:
    assert property (wdt_service |-> $past(wr_wdc && key_half_r && key_in == KEY_SECOND))
    else $error("service without second key");

  a_regular_mode_quiet:
    assert property (wdt_service |-> $past(mode_r) == MODE_WATCHDOG)
    else $error("service outside watchdog mode");

  a_mode_gates_active:
    assert property (state_r != ST_OFF |-> $past(mode_r == MODE_WATCHDOG || state_r != ST_OFF))
    else $error("watchdog left off state outside watchdog mode");

  a_flag_on_timeout:
    assert property (flag_set |=> flag_r [*1] ##0 ist_r[IRQ_TIMEOUT])
    else $error("time-out did not set flag");

  a_status_sticky:
    assert property (ist_r[IRQ_TIMEOUT] && !wr_icl |=> ist_r[IRQ_TIMEOUT])
    else $error("time-out status dropped without clear");

  a_flag_w1c:
    assert property (wr_wdc && pwdata[FLAG_BIT] && !flag_set |=> !flag_r)
    else $error("write one did not clear flag");

  a_flag_enable_clear:
    assert property (wr_wdc && pwdata[EN_BIT] && !en_r && !flag_set |=> !flag_r && en_r)
    else $error("enabling did not clear flag");

  a_enable_bit:
    assert property (wr_wdc && state_r != ST_ACTIVE && !key_done |=> en_r == $past(pwdata[EN_BIT]))
    else $error("enable bit not written");

  a_active_enabled:
    assert property (wdt_active |-> en_r)
    else $error("active watchdog reads disabled");

  a_half_frozen:
    assert property (wdt_active && $past(wdt_active) |-> $stable(lower_half_run) && $stable(upper_half_run))
    else $error("half run control changed while active");

  a_rsv_low_zero:
    assert property (access_ph && !pwrite && hit(paddr, WDC_OFS) |-> prdata[11:0] == 12'h000)
    else $error("reserved bits read nonzero");

endmodule

/* sim/test_watchdog_control_service_logic.sv */
// Self-checking testbench for the watchdog control and service logic
`timescale 1ns/1ps
module test_watchdog_control_service_logic;
  import watchdog_ctrl_pkg::*;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              wdt_expire;
  logic              wdt_service;
  logic              wdt_armed;
  logic              wdt_active;
  logic [1:0]        timer_mode;
  logic              lower_half_run;
  logic              upper_half_run;
  logic              irq;
  int                miscompares;
  int                num_checks;
  int                svc_count;
  logic [31:0]       rd;
  logic              err;

  watchdog_control_service_logic watchdog_control_service_logic_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_expire(wdt_expire), .wdt_service(wdt_service), .wdt_armed(wdt_armed),
    .wdt_active(wdt_active), .timer_mode(timer_mode), .lower_half_run(lower_half_run),
    .upper_half_run(upper_half_run), .irq(irq)
  );

  always #2.5 pclk = ~pclk;

  // Service pulses seen since the last scenario cleared the count
  always @(negedge pclk) begin
    if (wdt_service === 1'b1) svc_count++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    if (n >= 50) chk(1'b0, 1'b1, "pready");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse_expire();
    wdt_expire <= 1'b1;
    @(posedge pclk);
    wdt_expire <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset_and_fields();
    apb(0, WDC_OFS, 0); chk(rd, 32'h0000_0000, "ctrl reset");
    apb(1, WDC_OFS, 32'h1234_0FFF);
    apb(0, WDC_OFS, 0); chk(rd, 32'h1234_0000, "key rw, low reserved");
    $display("test reset_and_fields done");
  endtask

  task automatic t_no_service_other_mode();
    svc_count = 0;
    apb(1, TGC_OFS, 32'h0000_0003);
    apb(1, WDC_OFS, 32'hA5C6_4000);
    apb(1, WDC_OFS, 32'hDA7E_4000);
    repeat (2) @(posedge pclk);
    chk(svc_count, 0, "service in timer mode");
    chk(wdt_active, 1'b0, "active in timer mode");
    $display("test no_service_other_mode done");
  endtask

  task automatic t_service_sequence();
    svc_count = 0;
    apb(1, TGC_OFS, 32'h0000_000B);
    chk(timer_mode, MODE_WATCHDOG, "mode");
    apb(1, WDC_OFS, 32'h0000_4000);
    chk(wdt_armed, 1'b1, "armed");
    apb(1, WDC_OFS, 32'hA5C6_4000);
    apb(1, WDC_OFS, 32'h1111_4000);
    apb(1, WDC_OFS, 32'hDA7E_4000);
    chk(svc_count, 0, "broken sequence");
    apb(0, IST_OFS, 0); chk(rd[IRQ_BADKEY], 1'b1, "bad key status");
    apb(1, WDC_OFS, 32'hA5C6_4000);
    apb(0, TGC_OFS, 0);
    apb(1, WDC_OFS, 32'hDA7E_4000);
    chk(svc_count, 1, "service pulse");
    chk(wdt_active, 1'b1, "active");
    apb(0, WDC_OFS, 0); chk(rd, 32'hDA7E_4000, "ctrl readback");
    apb(1, TGC_OFS, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    chk({lower_half_run, upper_half_run}, 2'b11, "half runs frozen");
    $display("test service_sequence done");
  endtask

  task automatic t_timeout_flag();
    apb(1, IEN_OFS, 32'h0000_0001);
    chk(irq, 1'b0, "irq idle");
    pulse_expire();
    apb(0, WDC_OFS, 0); chk(rd[FLAG_BIT], 1'b1, "flag set");
    chk(irq, 1'b1, "irq raised");
    apb(1, WDC_OFS, 32'h0000_C000);
    apb(0, WDC_OFS, 0); chk(rd, 32'h0000_4000, "flag w1c");
    apb(1, IEN_OFS, 32'h0000_0000);
    chk(irq, 1'b0, "irq masked");
    apb(1, IEN_OFS, 32'h0000_0001);
    apb(1, ICL_OFS, 32'h0000_0007);
    chk(irq, 1'b0, "irq cleared");
    apb(0, 8'h20, 0); chk(err, 1'b1, "unmapped error");
    pulse_expire();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(wdt_active, 1'b0, "active after reset");
    apb(0, WDC_OFS, 0); chk(rd, 32'h0000_0000, "flag after reset");
    $display("test timeout_flag done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; wdt_expire = 0;
    miscompares = 0; num_checks = 0; svc_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_and_fields();
    t_no_service_other_mode();
    t_service_sequence();
    t_timeout_flag();
    print_verdict();
  end
endmodule
